// ===== logic/low_power_mode_select.sv
`timescale 1ns/10ps
// Summary of operation
// R01: fast halt: direct flag picks subactive or not
// R02: subactive halt: direct flag picks high-speed
// R03: fast halt with low-speed: watch or subactive
// R04: subactive halt, low-speed 0: watch/high-speed
// R05: watch exit resumes high-speed or subactive
// R06: subclock sampled at clock/32 or clock/4
// R07: software keeps fast rate off >=5MHz
// R08: enable bit gates subclock pin input
// R09: bit 3 writable, software never sets
// R10: bits 2..0 read zero, ignore writes
// R11: standby select 0 gives sleep
// R12: halt enters rest, interrupt resumes execution
// R13: software clears divider before low-speed moves
// R14: destination from three bits, default sleeps
module low_power_mode_select (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // register bus
  input wire low_power_pkg::avm_req_s avm_req_i,
  output low_power_pkg::avm_rsp_s avm_rsp_o,
  // cpu events
  input wire logic halt_i,
  input wire logic interrupt_i,
  // subclock pin and result
  input wire logic subclock_input_pin_i,
  output logic subclock_o,
  // mode state
  output low_power_pkg::mode_e mode_o,
  output logic halted_o
);

  logic [7:0] lpc_q;  // low_power_control
  logic [7:0] lpc_d;
  logic [7:0] sbc_q;  // standby control
  logic [7:0] sbc_d;
  low_power_pkg::mode_e mode_d;  // next operating mode
  low_power_pkg::mode_e return_q;  // mode resumed on sleep exit
  low_power_pkg::mode_e return_d;
  low_power_pkg::mode_e halt_dest;  // destination of a halt
  low_power_pkg::mode_e run_mode;  // running speed from the divider
  logic halted_d;
  low_power_pkg::avm_rsp_s rsp_d;
  logic access;  // request present
  logic commit;  // request completes this edge
  logic direct_transfer_flag;  // halt may jump straight to a running mode
  logic low_speed_select;  // halt and watch exit favour subclock modes
  logic standby_select;  // halt goes past plain sleep

  assign direct_transfer_flag = lpc_q[low_power_pkg::DIRECT_BIT];
  assign low_speed_select = lpc_q[low_power_pkg::LOW_SPEED_BIT];
  assign standby_select = sbc_q[low_power_pkg::STANDBY_SEL_BIT];
  assign access = avm_req_i.read | avm_req_i.write;
  assign commit = access & ~avm_rsp_o.waitrequest;

  // bus answer: wait one cycle, then release for a single edge
  always_comb begin
    rsp_d.waitrequest = ~(access & avm_rsp_o.waitrequest);
    rsp_d.readdata = avm_rsp_o.readdata;
    if (avm_req_i.read && avm_rsp_o.waitrequest) begin
      if (avm_req_i.address == low_power_pkg::LPC_OFFSET) begin
        // reserved low bits read zero, bit 3 reads what was stored
        rsp_d.readdata = {24'h000000, lpc_q[7:low_power_pkg::RSVD_BIT],
                          {low_power_pkg::RSVD_BIT{1'b0}}};  // [R10] [R09]
      end else if (avm_req_i.address == low_power_pkg::SBC_OFFSET) begin
        rsp_d.readdata = {24'h000000, sbc_q};
      end else if (avm_req_i.address == low_power_pkg::STAT_OFFSET) begin
        rsp_d.readdata = {28'h0000000, halted_o, mode_o};
      end else begin
        rsp_d.readdata = 32'h00000000;  // unmapped reads zero
      end
    end
  end

  // register writes take effect on the completing edge
  always_comb begin
    lpc_d = lpc_q;
    sbc_d = sbc_q;
    if (commit && avm_req_i.write) begin
      if (avm_req_i.address == low_power_pkg::LPC_OFFSET) begin
        lpc_d = {avm_req_i.writedata[7:low_power_pkg::RSVD_BIT],
                 {low_power_pkg::RSVD_BIT{1'b0}}};  // [R10] [R09]
      end else if (avm_req_i.address == low_power_pkg::SBC_OFFSET) begin
        sbc_d = avm_req_i.writedata[7:0];
      end
    end
  end

  // running speed and halt destination
  always_comb begin
    if (sbc_q[low_power_pkg::DIVIDER_LSB +: low_power_pkg::DIVIDER_W]
        == low_power_pkg::DIVIDER_UNDIVIDED) begin
      run_mode = low_power_pkg::MODE_HIGH;
    end else begin
      run_mode = low_power_pkg::MODE_MEDIUM;
    end
    halt_dest = low_power_pkg::MODE_SLEEP;
    if (mode_o == low_power_pkg::MODE_SUBACTIVE) begin
      if (!standby_select) begin
        halt_dest = low_power_pkg::MODE_SUBSLEEP;  // [R11]
      end else if (!low_speed_select && direct_transfer_flag) begin
        halt_dest = low_power_pkg::MODE_HIGH;  // [R02] [R04]
      end else if (!direct_transfer_flag) begin
        halt_dest = low_power_pkg::MODE_WATCH;  // [R02] [R04]
      end else begin
        halt_dest = low_power_pkg::MODE_SUBSLEEP;  // [R14]
      end
    end else begin
      if (!standby_select) begin
        halt_dest = low_power_pkg::MODE_SLEEP;  // [R11]
      end else if (!low_speed_select) begin
        halt_dest = low_power_pkg::MODE_STANDBY;  // [R03] [R01]
      end else if (direct_transfer_flag) begin
        halt_dest = low_power_pkg::MODE_SUBACTIVE;  // [R01] [R03]
      end else begin
        halt_dest = low_power_pkg::MODE_WATCH;  // [R01] [R03]
      end
    end
  end

  // operating mode transitions
  always_comb begin
    mode_d = mode_o;
    return_d = return_q;
    case (mode_o)
      low_power_pkg::MODE_HIGH, low_power_pkg::MODE_MEDIUM: begin
        // only the halt instruction leaves execution
        if (halt_i) begin
          mode_d = halt_dest;  // [R12] [R14]
          return_d = mode_o;
        end else begin
          mode_d = run_mode;
        end
      end
      low_power_pkg::MODE_SUBACTIVE: begin
        if (halt_i) begin
          mode_d = halt_dest;  // [R12] [R14]
          return_d = low_power_pkg::MODE_SUBACTIVE;
        end
      end
      low_power_pkg::MODE_SLEEP, low_power_pkg::MODE_SUBSLEEP: begin
        // only an interrupt resumes execution
        if (interrupt_i) begin
          mode_d = return_q;  // [R12]
        end
      end
      low_power_pkg::MODE_STANDBY: begin
        if (interrupt_i) begin
          mode_d = run_mode;  // [R12]
        end
      end
      low_power_pkg::MODE_WATCH: begin
        if (interrupt_i && low_speed_select) begin
          mode_d = low_power_pkg::MODE_SUBACTIVE;  // [R05]
        end else if (interrupt_i) begin
          mode_d = low_power_pkg::MODE_HIGH;  // [R05]
        end
      end
      default: begin
        mode_d = low_power_pkg::MODE_HIGH;
      end
    endcase
    halted_d = (mode_d == low_power_pkg::MODE_SLEEP)
            || (mode_d == low_power_pkg::MODE_SUBSLEEP)
            || (mode_d == low_power_pkg::MODE_STANDBY)
            || (mode_d == low_power_pkg::MODE_WATCH);  // [R12]
  end

  // state registers
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lpc_q <= low_power_pkg::LPC_RESET;
      sbc_q <= low_power_pkg::SBC_RESET;
      mode_o <= low_power_pkg::MODE_HIGH;
      return_q <= low_power_pkg::MODE_HIGH;
      halted_o <= 1'b0;
      avm_rsp_o <= '{waitrequest: 1'b1, readdata: 32'h00000000};
    end else begin
      lpc_q <= lpc_d;
      sbc_q <= sbc_d;
      mode_o <= mode_d;
      return_q <= return_d;
      halted_o <= halted_d;
      avm_rsp_o <= rsp_d;
    end
  end

  // subclock pin sampling
  subclock_sampler u_sampler (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .fast_rate_i(lpc_q[low_power_pkg::NOISE_RATE_BIT]),
    .enable_i(lpc_q[low_power_pkg::SUB_ENABLE_BIT]),
    .pin_i(subclock_input_pin_i),
    .sample_o(subclock_o)
  );

endmodule : low_power_mode_select

// ===== logic/low_power_pkg.sv
package low_power_pkg;

  // register word offsets (byte addresses)
  localparam logic [3:0] LPC_OFFSET = 4'h0;  // low_power_control
  localparam logic [3:0] SBC_OFFSET = 4'h4;  // standby_select and system_clock_divider
  localparam logic [3:0] STAT_OFFSET = 4'h8;  // current operating mode

  // low_power_control field positions
  localparam int DIRECT_BIT = 7;  // direct_transfer_flag
  localparam int LOW_SPEED_BIT = 6;  // low_speed_select
  localparam int NOISE_RATE_BIT = 5;  // noise_sample_rate_select
  localparam int SUB_ENABLE_BIT = 4;  // subclock_input_enable
  localparam int RSVD_BIT = 3;  // lowest stored bit, bits below read zero

  // standby control field positions
  localparam int STANDBY_SEL_BIT = 7;  // standby_select
  localparam int DIVIDER_LSB = 0;  // system_clock_divider
  localparam int DIVIDER_W = 3;

  // reset values
  localparam logic [7:0] LPC_RESET = 8'h00;
  localparam logic [7:0] SBC_RESET = 8'h00;
  localparam logic [DIVIDER_W-1:0] DIVIDER_UNDIVIDED = 3'h0;  // undivided code

  // noise sampling divides
  localparam int SAMPLE_DIV_SLOW = 32;
  localparam int SAMPLE_DIV_FAST = 4;
  localparam int SAMPLE_CNT_W = 5;

  // operating modes
  typedef enum logic [2:0] {
    MODE_HIGH,
    MODE_MEDIUM,
    MODE_SLEEP,
    MODE_STANDBY,
    MODE_WATCH,
    MODE_SUBACTIVE,
    MODE_SUBSLEEP
  } mode_e;

  // avalon request from the master
  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [31:0] writedata;
  } avm_req_s;

  // avalon answer to the master
  typedef struct packed {
    logic waitrequest;
    logic [31:0] readdata;
  } avm_rsp_s;

endpackage : low_power_pkg

// ===== logic/subclock_sampler.sv
`timescale 1ns/10ps
// samples the external subclock pin at a rate derived from the system clock
module subclock_sampler (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // control
  input wire logic fast_rate_i,
  input wire logic enable_i,
  // pin and sampled result
  input wire logic pin_i,
  output logic sample_o
);

  logic sync1_q;  // first synchroniser stage
  logic sync2_q;  // second synchroniser stage
  logic [low_power_pkg::SAMPLE_CNT_W-1:0] cnt_q;  // sampling divider
  logic [low_power_pkg::SAMPLE_CNT_W-1:0] cnt_d;
  logic [low_power_pkg::SAMPLE_CNT_W-1:0] last;  // terminal count for the rate
  logic tick;  // one-cycle sample enable
  logic sample_d;

  // terminal count and sample enable
  always_comb begin
    if (fast_rate_i) begin
      last = low_power_pkg::SAMPLE_CNT_W'(low_power_pkg::SAMPLE_DIV_FAST - 1);
    end else begin
      last = low_power_pkg::SAMPLE_CNT_W'(low_power_pkg::SAMPLE_DIV_SLOW - 1);
    end
    tick = (cnt_q >= last);  // [R06]
    if (tick) begin
      cnt_d = '0;
    end else begin
      cnt_d = cnt_q + 1'b1;
    end
    // pin is ignored while input disabled
    if (!enable_i) begin
      sample_d = 1'b0;  // [R08]
    end else if (tick) begin
      sample_d = sync2_q;  // [R06]
    end else begin
      sample_d = sample_o;
    end
  end

  // synchroniser, divider and sample registers
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      cnt_q <= '0;
      sample_o <= 1'b0;
    end else begin
      sync1_q <= pin_i;
      sync2_q <= sync1_q;
      cnt_q <= cnt_d;
      sample_o <= sample_d;
    end
  end

endmodule : subclock_sampler

// ===== test/lpms_sva.sv
`timescale 1ns/10ps
// checks mode moves and reserved read bits at the block's ports
module lpms_sva (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // watched ports
  input wire low_power_pkg::avm_req_s avm_req_i,
  input wire low_power_pkg::avm_rsp_s avm_rsp_o,
  input wire logic halt_i,
  input wire logic interrupt_i,
  input wire low_power_pkg::mode_e mode_o,
  input wire logic halted_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // mode codes: 2 sleep, 3 standby, 4 watch, 5 subactive, 6 subsleep
  rsvd_zero_a:
  assert property (!avm_rsp_o.waitrequest && avm_req_i.read && avm_req_i.address == 4'h0
    |-> avm_rsp_o.readdata[2:0] == 3'h0) else $error("reserved bits not zero");
  halted_mode_a:
  assert property (halted_o == (mode_o inside {3'h2, 3'h3, 3'h4, 3'h6}))
    else $error("halted flag disagrees with mode");
  halt_only_a:
  assert property ($rose(halted_o) |-> $past(halt_i)) else $error("halt without halt pulse");
  wake_irq_a:
  assert property ($fell(halted_o) |-> $past(interrupt_i)) else $error("wake without interrupt");
  subsleep_exit_a:
  assert property (mode_o == 3'h6 && interrupt_i |=> mode_o == 3'h5)
    else $error("subsleep wake wrong");
  watch_exit_a:
  assert property (mode_o == 3'h4 && interrupt_i |=> mode_o inside {3'h0, 3'h1, 3'h5})
    else $error("watch wake wrong");
  fast_halt_a:
  assert property (mode_o inside {3'h0, 3'h1} && halt_i |=> mode_o inside {[3'h2:3'h5]})
    else $error("halt from fast mode wrong");
  sub_halt_a:
  assert property (mode_o == 3'h5 && halt_i |=> mode_o inside {3'h0, 3'h4, 3'h6})
    else $error("halt from subactive wrong");
endmodule : lpms_sva

bind low_power_mode_select lpms_sva chk_i (.clk_i, .resetn_i, .avm_req_i, .avm_rsp_o,
  .halt_i, .interrupt_i, .mode_o, .halted_o);

// ===== test/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic clk_i = 0;
  logic resetn_i = 0;
  low_power_pkg::avm_req_s req = '0;
  low_power_pkg::avm_rsp_s rsp;
  logic halt_i = 0;
  logic irq = 0;
  logic pin = 0;
  logic sub;
  low_power_pkg::mode_e mode;
  logic halted;
  int mismatches = 0;
  int cmp_count = 0;
  int cyc = 0;
  int t1;
  int t2;
  // 40 MHz system clock and cycle count
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) cyc <= cyc + 1;
  low_power_mode_select uut (.clk_i(clk_i), .resetn_i(resetn_i), .avm_req_i(req),
    .avm_rsp_o(rsp), .halt_i(halt_i), .interrupt_i(irq), .subclock_input_pin_i(pin),
    .subclock_o(sub), .mode_o(mode), .halted_o(halted));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    req <= '{!w, w, a, {24'h0, d}};
    @(posedge clk_i);
    while (rsp.waitrequest !== 1'b0) @(posedge clk_i);
    q = rsp.readdata;
    req <= '0;
    @(posedge clk_i);
  endtask : bus
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, {24'h0, e});
  endtask : rd
  // set both registers, pulse halt or interrupt, compare the new mode
  task automatic go(input logic [7:0] sb, input logic [7:0] lp, input logic h,
                    input logic [2:0] e);
    wr(low_power_pkg::SBC_OFFSET, sb);
    wr(low_power_pkg::LPC_OFFSET, lp);
    halt_i <= h;
    irq <= !h;
    @(posedge clk_i);
    halt_i <= 0;
    irq <= 0;
    @(posedge clk_i);
    chk({29'h0, mode}, {29'h0, e});
  endtask : go
  // toggle the pin and wait for the sampled copy, noting the cycle
  task automatic follow(input logic v, output int t);
    pin <= v;
    t = cyc;
    do @(posedge clk_i); while (sub !== v && cyc - t < 40);
    chk({31'h0, sub}, {31'h0, v});
    t = cyc;
  endtask : follow
  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  // watchdog against a hung handshake
  initial begin
    #200us;
    mismatches++;
    end_sim();
  end
  // register access and reserved bits
  task automatic reg_scenario;
    rd(low_power_pkg::LPC_OFFSET, 8'h00);
    rd(low_power_pkg::STAT_OFFSET, 8'h00);
    rd(4'hc, 8'h00);
    wr(low_power_pkg::LPC_OFFSET, 8'hd7);
    rd(low_power_pkg::LPC_OFFSET, 8'hd0);
  endtask : reg_scenario
  // every halt destination and wake path, divider cleared for slow moves
  task automatic mode_scenario;
    go(8'h00, 8'h00, 1, 3'h2);
    go(8'h00, 8'h00, 0, 3'h0);
    go(8'h80, 8'h00, 1, 3'h3);
    go(8'h80, 8'h00, 0, 3'h0);
    go(8'h80, 8'h40, 1, 3'h4);
    go(8'h80, 8'h40, 0, 3'h5);
    go(8'h00, 8'h40, 1, 3'h6);
    go(8'h00, 8'h40, 0, 3'h5);
    go(8'h80, 8'h40, 1, 3'h4);
    go(8'h80, 8'h40, 0, 3'h5);
    go(8'h80, 8'h00, 1, 3'h4);
    go(8'h80, 8'h00, 0, 3'h0);
    go(8'h80, 8'hc0, 1, 3'h5);
    go(8'h80, 8'hc0, 1, 3'h6);
    go(8'h80, 8'hc0, 0, 3'h5);
    go(8'h80, 8'h80, 1, 3'h0);
    go(8'h81, 8'h00, 1, 3'h3);
    go(8'h81, 8'h00, 0, 3'h1);
  endtask : mode_scenario
  // reset in mid-run from a halted state clears mode and registers
  task automatic reset_scenario;
    go(8'h00, 8'h00, 1, 3'h2);
    resetn_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    rd(low_power_pkg::STAT_OFFSET, 8'h00);
    rd(low_power_pkg::LPC_OFFSET, 8'h00);
  endtask : reset_scenario
  // pin gating and the slow sampling rate
  task automatic sampler_scenario;
    wr(low_power_pkg::LPC_OFFSET, 8'h00);
    pin <= 1;
    repeat (40) @(posedge clk_i);
    chk({31'h0, sub}, 32'h0);
    wr(low_power_pkg::LPC_OFFSET, 8'h10);
    follow(1, t1);
    repeat (5) @(posedge clk_i);
    follow(0, t2);
    chk((t2 - t1) % 32, 32'h0);
  endtask : sampler_scenario
  initial begin
    repeat (4) @(posedge clk_i);
    resetn_i <= 1;
    @(posedge clk_i);
    reg_scenario();
    mode_scenario();
    reset_scenario();
    sampler_scenario();
    end_sim();
  end
endmodule : testbench
